// [inc/fpec_pkg.sv]
/*
 Package for the flash program/erase parameter checker: result byte layout,
 unlock value, address map of flash and routine RAM, request kinds.
 Assumes one 50 MHz clock and a synchronous active-high reset.
*/
package fpec_pkg;
    localparam logic [7:0] FPEC_UNLOCK_VALUE = 8'h5a;
    localparam int FPEC_BIT_SUCCESS = 0;
    localparam int FPEC_BIT_DEST = 1;
    localparam int FPEC_BIT_SRC = 2;
    localparam int FPEC_BIT_KEY = 4;
    localparam int FPEC_BIT_PROTECT = 6;
    localparam logic [7:0] FPEC_RESULT_RESET = 8'h00;
    localparam logic [15:0] FPEC_ONEHOT_RESET = 16'h0000;
    localparam logic [31:0] FPEC_FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FPEC_FLASH_LIMIT = 32'h0003_ffff;
    localparam logic [31:0] FPEC_RAM_ROUTINE_BASE = 32'hffff_9000;
    localparam logic [31:0] FPEC_RAM_ROUTINE_LIMIT = 32'hffff_afff;
    localparam logic [31:0] FPEC_BANK_SIZE = 32'h0002_0000;
    localparam int FPEC_ALIGN_BITS = 7;
    localparam int FPEC_BLOCK_COUNT = 16;
    localparam logic [23:0] FPEC_BLOCK_UPPER_ZERO = 24'h000000;

    typedef enum logic [1:0] {
        FPEC_REQ_NONE,
        FPEC_REQ_PROGRAM,
        FPEC_REQ_ERASE
    } fpec_req_type;

    typedef struct packed {
        logic [31:0] source_address;
        logic [31:0] dest_address;
        logic [31:0] second_dest_address;
        logic dual_bank;
    } fpec_prog_args_type;
endpackage

// [rtl/fpec_checker.sv]
/*
 Parameter checker: on a one-cycle call strobe, checks the unlock key, the
 program source and destination addresses or the erase block selection, and
 returns one consistent result byte with a done pulse.
 Assumes the caller holds arguments stable in the cycle of the call strobe.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RL1: Key must equal 5A, else bit 4
// RL2: Software loads key before programming
// RL3: Source in flash or routine RAM: bit 2
// RL4: Destination outside flash sets bit 1
// RL5: Dual-bank same bank sets bit 1
// RL6: Bit 0 reports any error
// RL7: Software passes erase block number
// RL8: One block per call, 0 to 15
// RL9: Only a single index encodes selection
// RL10: Software zeroes parameter bits 31 to 8
// RL11: Block number above 15 flags error
// RL12: Unaligned 128-byte destination sets bit 1
// RL13: Bit 6 set when protection state entered
// RL14: All flags written together, reserved zero
module fpec_checker
    import fpec_pkg::*;
#(
    parameter int BLOCKS = FPEC_BLOCK_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic call_valid,
    input wire fpec_req_type call_kind,
    input wire logic [7:0] unlock_key_register,
    input wire fpec_prog_args_type prog_args,
    input wire logic [31:0] erase_block_select,
    input wire logic error_protect_indicator,
    output logic done,
    output logic [7:0] program_result_flags,
    output logic erase_start,
    output logic [15:0] erase_block_onehot
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check: the one-hot output has room for sixteen blocks
    if (BLOCKS < 1 || BLOCKS > FPEC_BLOCK_COUNT) begin : g_bad_blocks
        $error("BLOCKS must be 1 to 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Call decoding
    function automatic logic is_call(input logic valid, input fpec_req_type kind);
        is_call = valid && (kind != FPEC_REQ_NONE);
    endfunction

    function automatic logic is_erase(input logic valid, input fpec_req_type kind);
        is_erase = valid && (kind == FPEC_REQ_ERASE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address classification
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a >= FPEC_FLASH_BASE) && (a <= FPEC_FLASH_LIMIT);
    endfunction

    function automatic logic in_routine_ram(input logic [31:0] a);
        in_routine_ram = (a >= FPEC_RAM_ROUTINE_BASE) && (a <= FPEC_RAM_ROUTINE_LIMIT);
    endfunction

    function automatic logic bank_of(input logic [31:0] a);
        bank_of = (a >= FPEC_BANK_SIZE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-parameter checks
    logic call_taken;
    logic erase_call;
    logic key_error_flag;
    logic source_data_address_error;
    logic dest_range_error;
    logic dest_align_error;
    logic dest_bank_error;
    logic destination_address_error;
    logic protection_state_error;
    logic block_upper_error;
    logic block_range_error;
    logic block_error;
    logic [7:0] erase_block_number;
    logic [7:0] program_outcome;
    logic [7:0] erase_outcome;
    logic [7:0] next_result;
    logic next_done;
    logic next_erase_start;
    wire logic [15:0] next_onehot;

    // Which call is taken this cycle
    always_comb begin
        call_taken = is_call(call_valid, call_kind);
        erase_call = is_erase(call_valid, call_kind);
    end

    always_comb begin
        key_error_flag = (unlock_key_register != FPEC_UNLOCK_VALUE); // [RL1]
    end

    always_comb begin
        source_data_address_error = in_flash(prog_args.source_address)
            || in_routine_ram(prog_args.source_address); // [RL3]
    end

    always_comb begin
        dest_range_error = !in_flash(prog_args.dest_address); // [RL4]
        dest_align_error = (prog_args.dest_address[FPEC_ALIGN_BITS-1:0] != '0); // [RL12]
        dest_bank_error = prog_args.dual_bank
            && (bank_of(prog_args.dest_address)
                == bank_of(prog_args.second_dest_address)); // [RL5]
        destination_address_error = dest_range_error || dest_align_error || dest_bank_error;
    end

    always_comb begin
        protection_state_error = error_protect_indicator; // [RL13]
    end

    always_comb begin
        erase_block_number = erase_block_select[7:0];
        block_upper_error = (erase_block_select[31:8] != FPEC_BLOCK_UPPER_ZERO);
        block_range_error = (erase_block_number >= 8'(BLOCKS)); // [RL11]
        block_error = block_upper_error || block_range_error; // [RL9]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result byte assembly: reserved bits stay zero
    function automatic logic [7:0] result_byte(
        input logic key_error,
        input logic protect_error,
        input logic source_error,
        input logic dest_error
    );
        logic [7:0] r;
        r = FPEC_RESULT_RESET; // [RL14]
        r[FPEC_BIT_KEY] = key_error;
        r[FPEC_BIT_PROTECT] = protect_error;
        r[FPEC_BIT_SRC] = source_error;
        r[FPEC_BIT_DEST] = dest_error;
        r[FPEC_BIT_SUCCESS] = |r[7:1]; // [RL6]
        return r;
    endfunction

    always_comb begin
        program_outcome = result_byte(key_error_flag, protection_state_error,
            source_data_address_error, destination_address_error);
        erase_outcome = result_byte(key_error_flag, protection_state_error, 1'b0, block_error);
    end

    always_comb begin
        unique case (call_kind)
            FPEC_REQ_PROGRAM: begin
                next_result = program_outcome;
            end
            FPEC_REQ_ERASE, FPEC_REQ_NONE: begin
                next_result = erase_outcome;
            end
            default: begin
                next_result = erase_outcome;
            end
        endcase
    end

    // Next values for the registered pulses
    always_comb begin
        next_done = call_taken;
        next_erase_start = erase_call && !next_result[FPEC_BIT_SUCCESS]; // [RL8]
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-hot block decode; blocks past BLOCKS never light
    for (genvar b = 0; b < FPEC_BLOCK_COUNT; b++) begin : g_onehot
        if (b < BLOCKS) begin : g_used
            assign next_onehot[b] = (erase_block_number == 8'(b)); // [RL8]
        end else begin : g_unused
            assign next_onehot[b] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result byte, written whole on each call
    always_ff @(posedge clk) begin
        if (rst) begin
            program_result_flags <= FPEC_RESULT_RESET;
        end else if (call_taken) begin
            program_result_flags <= next_result; // [RL14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion pulse, one cycle after each taken call
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Erase start pulse, only for a clean erase call
    always_ff @(posedge clk) begin
        if (rst) begin
            erase_start <= 1'b0;
        end else begin
            erase_start <= next_erase_start; // [RL8]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Single-block erase selection, held until the next clean erase
    always_ff @(posedge clk) begin
        if (rst) begin
            erase_block_onehot <= FPEC_ONEHOT_RESET;
        end else if (next_erase_start) begin
            erase_block_onehot <= next_onehot; // [RL8] [RL9]
        end
    end

endmodule
`default_nettype wire

// [bench/fpec_checker_assertions.sv]
/* Checker on fpec_checker ports; assumes a bind from the bench top. */
`timescale 1ns/10ps
`default_nettype none
module fpec_checker_assertions
    import fpec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic call_valid,
    input wire logic error_protect_indicator,
    input wire logic done,
    input wire logic erase_start,
    input wire fpec_req_type call_kind,
    input wire logic [7:0] unlock_key_register,
    input wire logic [7:0] program_result_flags,
    input wire logic [31:0] erase_block_select,
    input wire logic [15:0] erase_block_onehot
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic go = call_valid && call_kind != FPEC_REQ_NONE;
    wire logic ers = go && call_kind == FPEC_REQ_ERASE;
    wire logic [7:0] f = program_result_flags;
    a_done_latency: assert property (go |=> done) else $error("done");
    a_no_stray: assert property (!go |=> !done) else $error("stray");
    a_key_flag: assert property (go |=> f[4] == ($past(unlock_key_register) != 8'h5a))
        else $error("key");
    a_protect_flag: assert property (go |=> f[6] == $past(error_protect_indicator))
        else $error("protect");
    a_any_error: assert property (done |-> f[0] == |f[6:1]) else $error("sum");
    a_reserved_zero: assert property (done |-> !(f[7] | f[5] | f[3])) else $error("rsv");
    a_block_range: assert property (ers && erase_block_select > 32'hf
        |=> f[1] && !erase_start) else $error("range");
    a_one_block: assert property (erase_start |-> $past(ers) &&
        erase_block_onehot == 16'h1 << $past(erase_block_select[3:0])) else $error("onehot");
    a_flags_hold: assert property (!go |=> $stable(program_result_flags))
        else $error("flags changed without a call");
    a_onehot_hold: assert property (!ers |=> $stable(erase_block_onehot))
        else $error("onehot changed without an erase");
endmodule
`default_nettype wire

// [bench/fpec_cpu.sv]
/* CPU software model: loads key and arguments, strobes calls; assumes the bench clock. */
`timescale 1ns/10ps
`default_nettype none
module fpec_cpu
    import fpec_pkg::*;
(
    input wire logic clk,
    output logic call_valid,
    output logic error_protect_indicator,
    output var fpec_req_type call_kind,
    output logic [7:0] unlock_key_register,
    output var fpec_prog_args_type prog_args,
    output logic [31:0] erase_block_select
);
    initial {call_valid, error_protect_indicator, unlock_key_register, prog_args} = '0;
    initial begin
        erase_block_select = 32'h0000_0000;
        call_kind = FPEC_REQ_NONE;
    end
    task automatic call(inout integer s);
        logic [31:0] r, a;
        r = $random(s);
        a = $random(s);
        @(negedge clk);
        call_valid = |r[1:0];
        call_kind = fpec_req_type'(r[3:2] % 2'd3);
        unlock_key_register = r[4] ? 8'h5a : r[15:8];
        error_protect_indicator = r[7:5] == 3'h0;
        prog_args = {r[16] ? a & 32'h3ffff : r[17] ? 32'hffff9000 + a[12:0] : a,
            a & (r[18] ? 32'h3ff80 : 32'h7ffff), {a[7:0], a[31:8]} & 32'h3ff80, r[20]};
        erase_block_select = r[21] ? a & 32'h1f : a;
    endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
/* Bench top: random calls from the CPU model, each answer checked against a model. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin n_fail++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module testbench
    import fpec_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, call_valid, error_protect_indicator, done, erase_start;
    logic pend, xs, e;
    fpec_req_type call_kind;
    logic [7:0] unlock_key_register, program_result_flags, m, xf;
    fpec_prog_args_type prog_args;
    logic [31:0] erase_block_select, src, dst;
    logic [15:0] erase_block_onehot, xoh;
    integer seed = 32'h9e408425;
    int checks = 0, n_fail = 0;
    always #10 clk = ~clk;
    fpec_checker u_dut(
        .clk(clk),
        .rst(rst),
        .call_valid(call_valid),
        .call_kind(call_kind),
        .unlock_key_register(unlock_key_register),
        .prog_args(prog_args),
        .erase_block_select(erase_block_select),
        .error_protect_indicator(error_protect_indicator),
        .done(done),
        .program_result_flags(program_result_flags),
        .erase_start(erase_start),
        .erase_block_onehot(erase_block_onehot)
    );
    fpec_cpu u_cpu(
        .clk(clk),
        .call_valid(call_valid),
        .error_protect_indicator(error_protect_indicator),
        .call_kind(call_kind),
        .unlock_key_register(unlock_key_register),
        .prog_args(prog_args),
        .erase_block_select(erase_block_select)
    );
    always @(posedge clk) begin
        src = prog_args.source_address;
        dst = prog_args.dest_address;
        m = {1'b0, error_protect_indicator, 1'b0, unlock_key_register != 8'h5a,
            4'h0};
        if (call_kind == FPEC_REQ_ERASE) m[1] = erase_block_select > 15;
        else begin
            m[2] = src <= 32'h3ffff || src >= 32'hffff9000 && src <= 32'hffffafff;
            m[1] = dst > 32'h3ffff || dst[6:0] != 0 || prog_args.dual_bank &&
                dst[17] == prog_args.second_dest_address[17];
        end
        m[0] = |m;
        e = !rst && call_valid && call_kind == FPEC_REQ_ERASE && m == 8'h00;
        pend <= !rst && call_valid && call_kind != FPEC_REQ_NONE;
        xs <= e;
        if (rst) xf <= FPEC_RESULT_RESET;
        else if (call_valid && call_kind != FPEC_REQ_NONE) xf <= m;
        if (rst) xoh <= '0;
        else if (e) xoh <= 16'h1 << erase_block_select[3:0];
    end
    always @(negedge clk) if (!rst) begin
        `CHK("done", pend, done)
        `CHK("onehot", xoh, erase_block_onehot)
        `CHK("flags", xf, program_result_flags)
        `CHK("start", xs, erase_start)
    end
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 600; i++) begin
            rst = i % 300 < 2;
            u_cpu.call(seed);
        end
        repeat (2) @(negedge clk);
        conclude();
    end
endmodule
bind fpec_checker fpec_checker_assertions u_chk(
    .clk(clk),
    .rst(rst),
    .call_valid(call_valid),
    .error_protect_indicator(error_protect_indicator),
    .done(done),
    .erase_start(erase_start),
    .call_kind(call_kind),
    .unlock_key_register(unlock_key_register),
    .program_result_flags(program_result_flags),
    .erase_block_select(erase_block_select),
    .erase_block_onehot(erase_block_onehot)
);
`default_nettype wire
